// *** adcd_common.sv ***
// Shared constants and types for the dedicated-readings block, plus debounce
`timescale 1ns/1ps
`default_nettype none

package adcd_pkg;
  localparam int CODE_W = 10;
  localparam int SLOTS = 8;
  localparam int IDX_W = 3;
  // Channel numbers as seen by the converter input selector
  localparam logic [2:0] CH_BATTERY_TERMINAL_V = 3'h0;
  localparam logic [2:0] CH_BATTERY_TERMINAL_I = 3'h1;
  localparam logic [2:0] CH_SUPPLY = 3'h2;
  localparam logic [2:0] CH_CHRG_V = 3'h3;
  localparam logic [2:0] CH_CHRG_I = 3'h4;
  localparam logic [2:0] CH_THERM = 3'h5;
  localparam logic [2:0] CH_GEN6 = 3'h6;
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_FULL = 10'h3FF;
  localparam logic DIV_SEL_RESET = 1'b1;
  // Slow time base for the removal debounce
  localparam int SYS_CLK_HZ = 250_000_000;
  localparam int SLOW_HZ = 32768;
  localparam int SLOW_DIV = SYS_CLK_HZ / SLOW_HZ;
  localparam int DEBOUNCE_TICKS = 4;

  typedef struct packed {
    logic is_signed;
    logic [CODE_W-1:0] code;
  } adcd_result_s;
endpackage

// ****************************************************************
// Level debounce counted in slow time-base ticks
// ****************************************************************
module adcd_debounce #(
  parameter int TICKS = adcd_pkg::DEBOUNCE_TICKS
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Slow tick and raw level
  input wire logic tick_in,
  input wire logic level_in,
  // Debounced level and its rising edge
  output logic stable_out,
  output logic rise_out
);
  logic [7:0] count;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count <= 8'h00;
    end else if (!level_in) begin
      count <= 8'h00;
    end else if (tick_in && (count < 8'(TICKS))) begin
      count <= count + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stable_out <= 1'b0;
    end else begin
      stable_out <= level_in && (count >= 8'(TICKS));
    end
  end

  assign rise_out = level_in && (count >= 8'(TICKS)) && !stable_out;
endmodule

`default_nettype wire

// *** adcd_readings.sv ***
// Dedicated channel readings: sequencing, scaling controls, result slots
`timescale 1ns/1ps
`default_nettype none

module adcd_readings #(
  parameter int SLOW_DIV = adcd_pkg::SLOW_DIV,
  parameter int DEBOUNCE_TICKS = adcd_pkg::DEBOUNCE_TICKS
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Sequence control
  input wire logic start_in,
  input wire logic single_channel_mode_bit_in,
  input wire logic [2:0] first_channel_select_in,
  input wire logic battery_terminal_current_enable_in,
  input wire logic charger_current_enable_in,
  input wire logic charger_voltage_divider_select_in,
  input wire logic coin_cell_read_enable_in,
  // Battery removal detection
  input wire logic battery_terminal_removal_detect_enable_in,
  input wire logic app_on_in,
  input wire logic charger_supplied_in,
  input wire logic thermistor_high_in,
  // Converter core
  input wire logic core_done_in,
  input wire logic [9:0] core_code_in,
  // Result readout
  input wire logic [2:0] read_index_a_in,
  input wire logic [2:0] read_index_b_in,
  // Sequence status
  output logic busy_out,
  output logic done_out,
  // Converter core and analog steering
  output logic conv_req_out,
  output logic [2:0] conv_channel_out,
  output logic sample_both_out,
  output logic convert_held_out,
  output logic battery_terminal_current_path_out,
  output logic charger_current_path_out,
  output logic charger_div5_out,
  output logic coin_cell_route_out,
  // Results
  output adcd_pkg::adcd_result_s result_a_out,
  output adcd_pkg::adcd_result_s result_b_out,
  // Removal detection
  output logic battery_terminal_removal_sense_out,
  output logic battery_terminal_removal_irq_out
);
  typedef enum logic {ADCD_IDLE, ADCD_RUN} adcd_state_e;

  adcd_state_e state;
  logic [2:0] slot;
  logic [2:0] cur_ch;
  logic skip_zero;
  logic slot_write;
  logic cur_signed;
  adcd_pkg::adcd_result_s slot_mem [adcd_pkg::SLOTS];
  logic therm_meta;
  logic therm_sync;
  logic [12:0] div_count;
  logic slow_tick;
  logic detect_armed;
  logic removal_level;
  logic debounced_rise;

  // ****************************************************************
  // Channel of the current slot
  // ****************************************************************
  always_comb begin
    if (!single_channel_mode_bit_in) begin
      cur_ch = slot;
    end else if (first_channel_select_in == adcd_pkg::CH_BATTERY_TERMINAL_I) begin
      cur_ch = slot[0] ? adcd_pkg::CH_BATTERY_TERMINAL_I : adcd_pkg::CH_BATTERY_TERMINAL_V;
    end else begin
      cur_ch = first_channel_select_in;
    end
  end

  // A disabled current path gets no conversion at all
  assign skip_zero =
    ((cur_ch == adcd_pkg::CH_BATTERY_TERMINAL_I) && !battery_terminal_current_enable_in) ||
    ((cur_ch == adcd_pkg::CH_CHRG_I) && !charger_current_enable_in);
  assign cur_signed = (cur_ch == adcd_pkg::CH_BATTERY_TERMINAL_I) ||
    (cur_ch == adcd_pkg::CH_CHRG_I);
  assign slot_write = (state == ADCD_RUN) && (skip_zero || core_done_in);

  assign busy_out = (state == ADCD_RUN);
  assign conv_req_out = (state == ADCD_RUN) && !skip_zero;
  assign conv_channel_out = cur_ch;
  // Voltage sample also captures the sense difference for the next slot
  assign sample_both_out = conv_req_out &&
    (cur_ch == adcd_pkg::CH_BATTERY_TERMINAL_V) && battery_terminal_current_enable_in;
  assign convert_held_out = conv_req_out &&
    (cur_ch == adcd_pkg::CH_BATTERY_TERMINAL_I);
  assign battery_terminal_current_path_out = battery_terminal_current_enable_in;
  assign charger_current_path_out = charger_current_enable_in;
  // No disconnect gating: the reading stays valid on a weak cell
  assign coin_cell_route_out = coin_cell_read_enable_in;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ADCD_IDLE;
      slot <= 3'h0;
    end else begin
      unique case (state)
        ADCD_IDLE: begin
          if (start_in) begin
            state <= ADCD_RUN;
            slot <= 3'h0;
          end
        end
        ADCD_RUN: begin
          if (slot_write) begin
            slot <= slot + 3'h1;
            if (slot == adcd_pkg::LAST_SLOT) begin
              state <= ADCD_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= slot_write && (slot == adcd_pkg::LAST_SLOT);
    end
  end

  // ****************************************************************
  // Result slots
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < adcd_pkg::SLOTS; i++) begin
        slot_mem[i] <= '0;
      end
    end else if (slot_write) begin
      slot_mem[slot].is_signed <= cur_signed;
      // Core codes pass unchanged: unsigned or two's complement as converted
      slot_mem[slot].code <= skip_zero ? adcd_pkg::CODE_ZERO
                                       : core_code_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      result_a_out <= '0;
      result_b_out <= '0;
    end else begin
      result_a_out <= slot_mem[read_index_a_in];
      result_b_out <= slot_mem[read_index_b_in];
    end
  end

  // ****************************************************************
  // Charger voltage divider select
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      charger_div5_out <= adcd_pkg::DIV_SEL_RESET;
    end else begin
      charger_div5_out <= charger_voltage_divider_select_in;
    end
  end

  // ****************************************************************
  // Battery removal detection
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      therm_meta <= 1'b0;
      therm_sync <= 1'b0;
    end else begin
      therm_meta <= thermistor_high_in;
      therm_sync <= therm_meta;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_count <= 13'h0000;
      slow_tick <= 1'b0;
    end else begin
      slow_tick <= (div_count == 13'(SLOW_DIV - 1));
      div_count <= (div_count == 13'(SLOW_DIV - 1)) ? 13'h0000
                                                    : div_count + 13'h0001;
    end
  end

  assign detect_armed = battery_terminal_removal_detect_enable_in && app_on_in &&
    charger_supplied_in;
  assign removal_level = detect_armed && therm_sync;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      battery_terminal_removal_sense_out <= 1'b0;
    end else begin
      battery_terminal_removal_sense_out <= removal_level;
    end
  end

  adcd_debounce #(
    .TICKS(DEBOUNCE_TICKS)
  ) u_debounce (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .tick_in(slow_tick),
    .level_in(removal_level),
    .stable_out(),
    .rise_out(debounced_rise)
  );

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      battery_terminal_removal_irq_out <= 1'b0;
    end else begin
      battery_terminal_removal_irq_out <= debounced_rise;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_BATTERY_TERMINAL_I_ZERO: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    slot_write && (cur_ch == adcd_pkg::CH_BATTERY_TERMINAL_I) && !battery_terminal_current_enable_in
    |=> slot_mem[$past(slot)].code == adcd_pkg::CODE_ZERO)
    else $error("disabled battery current slot not zero");
  AST_CHRG_I_ZERO: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    slot_write && (cur_ch == adcd_pkg::CH_CHRG_I) &&
    !charger_current_enable_in
    |=> slot_mem[$past(slot)].code == adcd_pkg::CODE_ZERO)
    else $error("disabled charger current slot not zero");
  AST_NO_CONV_SKIP: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    busy_out && skip_zero |-> !conv_req_out ##1
    slot == $past(slot) + 3'h1)
    else $error("conversion requested for disabled path");
  AST_CODE_STORED: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    slot_write && !skip_zero
    |=> slot_mem[$past(slot)].code == $past(core_code_in) &&
    slot_mem[$past(slot)].is_signed == $past(cur_signed))
    else $error("converted code not stored");
  AST_PAIRS: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    busy_out && single_channel_mode_bit_in &&
    first_channel_select_in == adcd_pkg::CH_BATTERY_TERMINAL_I
    |-> conv_channel_out == {2'b00, slot[0]})
    else $error("battery pair interleave wrong");
  AST_CHRG_ALL: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    busy_out && single_channel_mode_bit_in &&
    first_channel_select_in == adcd_pkg::CH_CHRG_I
    |-> conv_channel_out == adcd_pkg::CH_CHRG_I)
    else $error("charger current not repeated");
  AST_MULTI: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    busy_out && !single_channel_mode_bit_in |-> conv_channel_out == slot)
    else $error("multiple channel order wrong");
  AST_SAMPLE_BOTH: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    convert_held_out && !$past(convert_held_out) &&
    $past(battery_terminal_current_enable_in) |-> $past(sample_both_out))
    else $error("battery pair not sampled together");
  AST_DIV_SEL: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    ##1 charger_div5_out == $past(charger_voltage_divider_select_in))
    else $error("divider select not followed");
  AST_SENSE: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    $rose(battery_terminal_removal_sense_out) |-> $past(detect_armed) &&
    $past(therm_sync))
    else $error("removal sense without armed detect");
  AST_IRQ: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    battery_terminal_removal_irq_out |-> battery_terminal_removal_sense_out ##1
    !battery_terminal_removal_irq_out)
    else $error("removal interrupt without sense");
  AST_DONE: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    done_out |-> !busy_out && $past(slot) == adcd_pkg::LAST_SLOT)
    else $error("sequence ended early");
endmodule

`default_nettype wire

// *** adcd_core_model.sv ***
// Behavioural converter core standing behind the readings block
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Converter core model
// ****************************************************************
module adcd_core_model #(
  parameter logic [79:0] LEVELS = 80'h0
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Request from the block and pacing from the bench
  input wire logic conv_req_in,
  input wire logic [2:0] conv_channel_in,
  input wire logic [1:0] latency_in,
  // Conversion result
  output logic core_done_out,
  output logic [9:0] core_code_out
);
  logic [1:0] wait_cnt;
  logic [9:0] level;

  assign level = LEVELS[conv_channel_in*10 +: 10];
  assign core_done_out = conv_req_in && (wait_cnt >= latency_in);
  // Code is scrambled outside a done cycle so a stale sample cannot match
  assign core_code_out = core_done_out ? level : ~level;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_cnt <= 2'h0;
    end else if (conv_req_in && !core_done_out) begin
      wait_cnt <= wait_cnt + 2'h1;
    end else begin
      wait_cnt <= 2'h0;
    end
  end
endmodule

`default_nettype wire

// *** adcd_readings_tb.sv ***
// Self-checking testbench for the dedicated readings block
`timescale 1ns/1ps
`default_nettype none

module adcd_readings_tb;
  // ****************************************************************
  // Wiring
  // ****************************************************************
  // Per-channel levels: ch0 full scale, ch1 most negative, ch4 most positive
  localparam logic [79:0] LEVELS = {10'h2AA, 10'h155, 10'h0AA, 10'h1FF,
    10'h354, 10'h215, 10'h200, 10'h3FF};
  logic clk = 1'b0, rst_b = 1'b0, start = 1'b0, single = 1'b0;
  logic bat_en = 1'b0, chg_en = 1'b0, div_sel = 1'b1, coin_en = 1'b0;
  logic det_en = 1'b0, app_on = 1'b0, chg_sup = 1'b0, therm = 1'b0;
  logic [2:0] sel = 3'h0, idx_a = 3'h0, idx_b = 3'h0;
  logic [1:0] lat = 2'h0;
  logic busy, done, req, both, held, bpath, cpath, div5, coin_rt;
  logic sense, irq, core_done;
  logic [2:0] ch;
  logic [9:0] core_code;
  adcd_pkg::adcd_result_s res_a, res_b;
  int fails = 0, comparisons = 0, n_both = 0, n_held = 0, n_irq = 0;
  logic [10:0] exp [8];

  always #2 clk = ~clk;
  always @(posedge clk) begin
    n_both += (both === 1'b1);
    n_held += (held === 1'b1);
    n_irq += (irq === 1'b1);
  end

  adcd_readings #(.SLOW_DIV(4), .DEBOUNCE_TICKS(2)) u_adcd_readings (
    .sys_clk_in(clk), .rst_b_in(rst_b), .start_in(start),
    .single_channel_mode_bit_in(single), .first_channel_select_in(sel),
    .battery_terminal_current_enable_in(bat_en), .charger_current_enable_in(chg_en),
    .charger_voltage_divider_select_in(div_sel),
    .coin_cell_read_enable_in(coin_en),
    .battery_terminal_removal_detect_enable_in(det_en), .app_on_in(app_on),
    .charger_supplied_in(chg_sup), .thermistor_high_in(therm),
    .core_done_in(core_done), .core_code_in(core_code),
    .read_index_a_in(idx_a), .read_index_b_in(idx_b),
    .busy_out(busy), .done_out(done), .conv_req_out(req),
    .conv_channel_out(ch), .sample_both_out(both),
    .convert_held_out(held), .battery_terminal_current_path_out(bpath),
    .charger_current_path_out(cpath), .charger_div5_out(div5),
    .coin_cell_route_out(coin_rt), .result_a_out(res_a),
    .result_b_out(res_b), .battery_terminal_removal_sense_out(sense),
    .battery_terminal_removal_irq_out(irq));

  adcd_core_model #(.LEVELS(LEVELS)) u_adcd_core_model (
    .sys_clk_in(clk), .rst_b_in(rst_b), .conv_req_in(req),
    .conv_channel_in(ch), .latency_in(lat), .core_done_out(core_done),
    .core_code_out(core_code));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  function automatic logic [10:0] slot(input logic [2:0] c, input logic en);
    return {c == 3'h1 || c == 3'h4, en ? LEVELS[c*10 +: 10] : 10'h000};
  endfunction

  task automatic check(input string what, input logic [10:0] seen,
      input logic [10:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic run_seq(input logic s, input logic [2:0] c,
      input logic be, input logic ce, input logic [1:0] l);
    int i;
    @(posedge clk);
    single <= s;
    sel <= c;
    bat_en <= be;
    chg_en <= ce;
    lat <= l;
    start <= 1'b1;
    n_both = 0;
    n_held = 0;
    @(posedge clk);
    start <= 1'b0;
    #1 check("busy after start", {10'h000, busy}, 11'h001);
    for (i = 0; i < 300 && done !== 1'b1; i++) @(posedge clk) #1;
    check("sequence done", {10'h000, done}, 11'h001);
    check("busy after done", {10'h000, busy}, 11'h000);
    check("current paths", {9'h000, bpath, cpath},
      {9'h000, be, ce});
  endtask

  task automatic check_slots();
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      idx_a <= 3'(k);
      idx_b <= 3'(7 - k);
      @(posedge clk);
      @(posedge clk) #1;
      check("slot via a", res_a, exp[k]);
      check("slot via b", res_b, exp[7 - k]);
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_multi(input logic en);
    run_seq(1'b0, 3'h5, en, en, 2'h0);
    for (int k = 0; k < 8; k++) exp[k] = slot(3'(k), en || (k != 1 && k != 4));
    check_slots();
    $display("multi channel test done, enables %0d", en);
  endtask

  task automatic t_pairs(input logic en);
    run_seq(1'b1, 3'h1, en, 1'b0, 2'h2);
    for (int k = 0; k < 8; k++) exp[k] = k[0] ? slot(3'h1, en) : slot(3'h0, 1);
    check_slots();
    check("both sampled", {10'h000, n_both > 0}, {10'h000, en});
    check("held converted", {10'h000, n_held > 0}, {10'h000, en});
    $display("battery pair test done, enable %0d", en);
  endtask

  task automatic t_single(input logic [2:0] c, input logic en);
    run_seq(1'b1, c, 1'b0, en, 2'h3);
    for (int k = 0; k < 8; k++) exp[k] = slot(c, en);
    check_slots();
    $display("single channel test done, channel %0d", c);
  endtask

  task automatic t_div_coin();
    check("divider after reset", {10'h000, div5}, 11'h001);
    @(posedge clk);
    div_sel <= 1'b0;
    coin_en <= 1'b1;
    @(posedge clk);
    @(posedge clk) #1;
    check("divide by ten", {10'h000, div5}, 11'h000);
    check("coin routed", {10'h000, coin_rt}, 11'h001);
    t_single(3'h6, 1'b1);
    @(posedge clk);
    div_sel <= 1'b1;
    coin_en <= 1'b0;
    @(posedge clk);
    @(posedge clk) #1;
    check("divide by five", {10'h000, div5}, 11'h001);
    check("coin unrouted", {10'h000, coin_rt}, 11'h000);
    $display("divider and coin cell test done");
  endtask

  task automatic t_removal(input logic arm);
    int i;
    @(posedge clk);
    det_en <= 1'b1;
    app_on <= 1'b1;
    chg_sup <= arm;
    therm <= 1'b1;
    n_irq = 0;
    for (i = 0; i < 6 && sense !== 1'b1; i++) @(posedge clk) #1;
    check("removal sense", {10'h000, sense}, {10'h000, arm});
    check("irq before debounce", 11'(n_irq), 11'h000);
    for (i = 0; i < 60; i++) @(posedge clk);
    check("removal irq count", 11'(n_irq), {10'h000, arm});
    @(posedge clk);
    therm <= 1'b0;
    chg_sup <= 1'b0;
    for (i = 0; i < 8; i++) @(posedge clk);
    $display("removal test done, armed %0d", arm);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk) #1;
    t_div_coin();
    t_multi(1'b1);
    t_multi(1'b0);
    t_pairs(1'b1);
    t_pairs(1'b0);
    t_single(3'h4, 1'b1);
    t_single(3'h4, 1'b0);
    t_removal(1'b1);
    t_removal(1'b0);
    stop_test();
  end

  // Whole run needs well under 20 us; a hang is cut at 100 us
  initial begin
    #100us;
    fails++;
    stop_test();
  end
endmodule

`default_nettype wire
